// ===== rtl/rsq_pkg.sv
// Package for the reset and initialization sequencer: timing counts, strap layout and the
// packed carriers shared by the sequencer. Assumes a 100 MHz system clock.
package rsq_pkg;

  localparam int unsigned CLK_SYS_MHZ = 100;
  localparam int unsigned CLK_SYS_NS  = 10;

  // Input qualification lengths: external resets in bus sync clock periods, power-on reset in primary clock periods.
  localparam int unsigned RST_IN_MIN_SYNC = 32;
  localparam int unsigned POR_IN_MIN      = 32;
  // Outbound assertion and release spacing, in bus sync clock periods.
  localparam int unsigned RST_OUT_MIN_SYNC  = 512;
  localparam int unsigned HARD_TO_SOFT_SYNC = 16;
  // Strap setup and drive-back timing.
  localparam int unsigned STRAP_SETUP_CLKS  = 4;
  localparam int unsigned STRAP_HOLD_NS     = 0;
  localparam int unsigned STRAP_OFF_MAX_NS  = 4;
  localparam int unsigned STRAP_ON_MIN_SYNC = 1;
  // Lock waits.
  localparam int unsigned PLL_LOCK_US    = 100;
  localparam int unsigned PLL_LOCK_CLKS  = (PLL_LOCK_US * 1000 + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam int unsigned DLL_LOCK_MIN   = 7680;
  localparam int unsigned DLL_LOCK_MAX   = 122880;
  // Clock input limits, for reference by the far side.
  localparam int unsigned CLK_IN_MAX_MHZ = 66;
  localparam int unsigned CLK_IN_MIN_NS  = 15;

  // Strap field layout.
  localparam int unsigned RST_SRC_W   = 3;
  localparam int unsigned STRAP_W     = 4;
  localparam int unsigned STRAP_DIV_B = 3;

  typedef struct packed {
    logic                 input_divider_strap;
    logic [RST_SRC_W-1:0] reset_source;
  } rsq_strap_t;

  // Open-drain pin: low-drive value and output enable.
  typedef struct packed {
    logic o;
    logic oe;
  } rsq_od_t;

  typedef enum logic [4:0] {
    ST_POR      = 5'h01,
    ST_PLL      = 5'h02,
    ST_ASSERT   = 5'h04,
    ST_SOFT_GAP = 5'h08,
    ST_RUN      = 5'h10
  } rsq_state_t;

endpackage : rsq_pkg

// ===== rtl/rsq_sequencer.sv
// Reset and initialization sequencer: qualifies reset inputs, drives open-drain hard and soft
// reset outward in order, latches strap pins and releases them while it drives hard reset low.
// Assumes clock pins and reset lines arrive asynchronously to clk_sys and are synchronised here.
//
// What this block does
// - Primary clock is the dedicated input in host mode, bus clock in agent.
// - Drive resets low at least 512 sync periods; soft released 16 after hard.
// - Stop driving strap pins within 4 ns of hard reset assertion; an external hard reset leaves them driven until qualified over 32 sync periods.
// - Drive strap pins again only one sync period after hard reset negates.
// - Strap set is three reset source bits plus one divider bit.
// - In host mode the sync clock derives from primary clock by divider strap.
// - Hard and soft reset lines only pull low or release.
// - Wait 100 us for PLL lock before using derived clocks.
// - Wait for DLL lock between 7680 and 122880 system bus clocks.
`timescale 1ns/1ns
`default_nettype none
module rsq_sequencer
  import rsq_pkg::*;
#(
  parameter int unsigned PLL_WAIT   = PLL_LOCK_CLKS,
  parameter int unsigned DLL_WAIT   = DLL_LOCK_MIN,
  parameter int unsigned SYNC_DIV_H = 2,
  parameter int unsigned SYNC_DIV_L = 1
) (
  // Clock and chip reset.
  input  wire  logic       clk_sys,
  input  wire  logic       rst_b,
  // Mode and clock pins.
  input  wire  logic       host_mode,
  input  wire  logic       primary_clock_in,
  input  wire  logic       bus_clock_in,
  // Power-on reset pin, active low.
  input  wire  logic       power_on_reset_in_b,
  // Open-drain reset lines.
  input  wire  logic       hard_reset_line_i,
  output logic             hard_reset_line_o,
  output logic             hard_reset_line_oe,
  input  wire  logic       soft_reset_line_i,
  output logic             soft_reset_line_o,
  output logic             soft_reset_line_oe,
  // Strap pins, shared with functional outputs after reset.
  input  wire  rsq_strap_t strap_i,
  input  wire  rsq_strap_t strap_func,
  output rsq_strap_t       strap_o,
  output logic             strap_oe,
  // Status.
  output rsq_strap_t       strap_latched,
  output logic             clocks_ready,
  output logic             sync_tick
);

  // Two-flop synchronisers for every pin input.
  logic [5:0] s1_q, s2_q;
  rsq_strap_t st1_q, st2_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1_q  <= 6'h00;
      s2_q  <= 6'h00;
      st1_q <= '0;
      st2_q <= '0;
    end else begin
      s1_q  <= {host_mode, primary_clock_in, bus_clock_in, power_on_reset_in_b,
                hard_reset_line_i, soft_reset_line_i};
      s2_q  <= s1_q;
      st1_q <= strap_i;
      st2_q <= st1_q;
    end
  end
  logic host_s, pclk_s, bclk_s, por_b_s, hard_s, soft_s;
  assign {host_s, pclk_s, bclk_s, por_b_s, hard_s, soft_s} = s2_q;

  logic clk_sel_q, clk_prev_q;
  wire  clk_sel_d = host_s ? pclk_s : bclk_s;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clk_sel_q  <= 1'b0;
      clk_prev_q <= 1'b0;
    end else begin
      clk_sel_q  <= clk_sel_d;
      clk_prev_q <= clk_sel_q;
    end
  end
  wire prim_edge = clk_sel_q & ~clk_prev_q;

  // sync tick: primary edges divided by the latched divider strap in host mode.
  logic [1:0] div_cnt_q;
  wire  [1:0] div_lim = strap_latched.input_divider_strap ? 2'(SYNC_DIV_H) : 2'(SYNC_DIV_L);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_q <= 2'h0;
      sync_tick <= 1'b0;
    end else begin
      sync_tick <= 1'b0;
      if (prim_edge) begin
        if (!host_s || div_cnt_q + 2'h1 >= div_lim) begin
          div_cnt_q <= 2'h0;
          sync_tick <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 2'h1;
        end
      end
    end
  end

  // power-on reset length in primary periods (sync periods in agent mode).
  logic [5:0] por_cnt_q;
  logic       por_ok_q;
  wire        por_step = prim_edge;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      por_cnt_q <= 6'h00;
      por_ok_q  <= 1'b0;
    end else if (por_b_s) begin
      // A qualification is spent by its release, so a later short pulse is never accepted.
      por_cnt_q <= 6'h00;
      por_ok_q  <= 1'b0;
    end else if (por_step && por_cnt_q < 6'(POR_IN_MIN)) begin
      por_cnt_q <= por_cnt_q + 6'h01;
    end else if (por_cnt_q >= 6'(POR_IN_MIN)) begin
      por_ok_q  <= 1'b1;
    end
  end

  // strap capture at power-on reset negation, after a qualified assertion.
  logic por_b_prev_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      por_b_prev_q  <= 1'b0;
      strap_latched <= '0;
    end else begin
      por_b_prev_q <= por_b_s;
      if (por_b_s && !por_b_prev_q && por_ok_q) begin
        strap_latched <= st2_q;
      end
    end
  end
  wire por_release = por_b_s & ~por_b_prev_q & por_ok_q;

  // external hard/soft reset input qualification in sync periods.
  logic [5:0] ext_cnt_q;
  logic       state_drv;
  wire        ext_low = (~hard_s | ~soft_s) & ~state_drv;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_cnt_q <= 6'h00;
    end else if (!ext_low) begin
      ext_cnt_q <= 6'h00;
    end else if (sync_tick && ext_cnt_q < 6'(RST_IN_MIN_SYNC)) begin
      ext_cnt_q <= ext_cnt_q + 6'h01;
    end
  end
  wire ext_req = ext_cnt_q >= 6'(RST_IN_MIN_SYNC);

  // Sequence state machine.
  rsq_state_t state_q;
  logic [16:0] wait_q;
  logic [9:0]  sync_cnt_q;
  assign state_drv = (state_q == ST_ASSERT) || (state_q == ST_SOFT_GAP) || (state_q == ST_PLL)
                     || (state_q == ST_POR);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= ST_POR;
      wait_q     <= 17'h00000;
      sync_cnt_q <= 10'h000;
    end else if (!por_b_s) begin
      state_q    <= ST_POR;
      wait_q     <= 17'h00000;
      sync_cnt_q <= 10'h000;
    end else begin
      case (state_q)
        ST_POR: begin
          if (por_release || por_ok_q) begin
            state_q <= ST_PLL;
            wait_q  <= 17'h00000;
          end
        end
        // lock waits before derived clocks count as usable.
        ST_PLL: begin
          wait_q <= wait_q + 17'h00001;
          if (wait_q >= 17'(PLL_WAIT + DLL_WAIT)) begin
            state_q    <= ST_ASSERT;
            sync_cnt_q <= 10'h000;
          end
        end
        // hold both lines low for the minimum sync periods.
        ST_ASSERT: begin
          if (sync_tick) begin
            sync_cnt_q <= sync_cnt_q + 10'h001;
            if (sync_cnt_q >= 10'(RST_OUT_MIN_SYNC - 1)) begin
              state_q    <= ST_SOFT_GAP;
              sync_cnt_q <= 10'h000;
            end
          end
        end
        // soft stays low after hard release.
        ST_SOFT_GAP: begin
          if (sync_tick) begin
            sync_cnt_q <= sync_cnt_q + 10'h001;
            if (sync_cnt_q >= 10'(HARD_TO_SOFT_SYNC - 1)) begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (ext_req) begin
            state_q    <= ST_ASSERT;
            sync_cnt_q <= 10'h000;
          end
        end
        default: state_q <= ST_POR;
      endcase
    end
  end

  // open-drain drive: value always low, only the enable moves.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hard_reset_line_o  <= 1'b0;
      hard_reset_line_oe <= 1'b1;
      soft_reset_line_o  <= 1'b0;
      soft_reset_line_oe <= 1'b1;
    end else begin
      hard_reset_line_o  <= 1'b0;
      soft_reset_line_o  <= 1'b0;
      hard_reset_line_oe <= state_drv && state_q != ST_SOFT_GAP;
      soft_reset_line_oe <= state_drv;
    end
  end

  // strap pins off while hard reset driven, back one sync period after release.
  logic hard_rel_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hard_rel_q   <= 1'b0;
      strap_oe     <= 1'b0;
      strap_o      <= '0;
      clocks_ready <= 1'b0;
    end else begin
      strap_o      <= strap_func;
      clocks_ready <= (state_q != ST_POR) && (state_q != ST_PLL);
      if (state_drv && state_q != ST_SOFT_GAP) begin
        hard_rel_q <= 1'b0;
        strap_oe   <= 1'b0;
      end else if (sync_tick && hard_s) begin
        hard_rel_q <= 1'b1;
        strap_oe   <= hard_rel_q;
      end
    end
  end

endmodule : rsq_sequencer
`default_nettype wire

// ===== tb/rsq_props.sv
// Checker for the reset sequencer, watching only its ports.
// Assumes the bench binds it to rsq_sequencer.
`timescale 1ns/1ns
`default_nettype none
module rsq_props
  import rsq_pkg::*;
#(
  parameter int unsigned PLL_WAIT = 20
) (
  // Watched ports.
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       power_on_reset_in_b,
  input wire logic       hard_reset_line_i,
  input wire logic       hard_reset_line_o,
  input wire logic       hard_reset_line_oe,
  input wire logic       soft_reset_line_o,
  input wire logic       soft_reset_line_oe,
  input wire logic       strap_oe,
  input wire rsq_strap_t strap_latched,
  input wire logic       clocks_ready,
  input wire logic       sync_tick
);
  logic [15:0] por_q;
  logic [15:0] hard_q;
  logic [15:0] soft_q;
  logic [15:0] line_q;
  // Saturating, so a long run never wraps into a false capture window.
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) por_q <= '0;
    else if (!power_on_reset_in_b) por_q <= '0;
    else if (por_q != 16'hffff) por_q <= por_q + 16'h1;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) hard_q <= '0;
    else if (!hard_reset_line_oe) hard_q <= '0;
    else hard_q <= hard_q + 16'(sync_tick);
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) soft_q <= '0;
    else if (hard_reset_line_oe || !soft_reset_line_oe) soft_q <= '0;
    else soft_q <= soft_q + 16'(sync_tick);
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) line_q <= '0;
    else if (!hard_reset_line_i) line_q <= '0;
    else line_q <= line_q + 16'(sync_tick);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_HARD_OD: assert property (hard_reset_line_oe |-> hard_reset_line_o == 1'b0)
    else $error("hard line driven high");
  AST_SOFT_OD: assert property (soft_reset_line_oe |-> soft_reset_line_o == 1'b0)
    else $error("soft line driven high");
  AST_STRAP_OFF: assert property (hard_reset_line_oe |-> !strap_oe)
    else $error("strap pins driven during hard reset");
  AST_HARD_LEN: assert property ($fell(hard_reset_line_oe) |-> hard_q >= 16'h0200)
    else $error("hard reset too short");
  AST_SOFT_GAP: assert property ($fell(soft_reset_line_oe) |-> soft_q >= 16'h0010)
    else $error("soft released too early");
  AST_SOFT_LAST: assert property (hard_reset_line_oe |-> soft_reset_line_oe)
    else $error("soft released before hard");
  AST_STRAP_BACK: assert property ($rose(strap_oe) |-> line_q >= 16'h0001)
    else $error("strap pins driven too soon");
  AST_LATCH_HOLD: assert property (por_q > 16'h0006 |-> $stable(strap_latched))
    else $error("latched straps changed");
  AST_PLL_WAIT: assert property ($rose(clocks_ready) |-> por_q >= PLL_WAIT)
    else $error("clocks ready too early");
  AST_LOCK_FIRST: assert property ($fell(hard_reset_line_oe) |-> clocks_ready)
    else $error("hard released before lock");
  AST_TICK: assert property (sync_tick |=> !sync_tick)
    else $error("sync tick longer than a cycle");
  cover property ($fell(soft_reset_line_oe));
  cover property ($rose(strap_oe));
  cover property (clocks_ready && $rose(hard_reset_line_oe));
endmodule : rsq_props
`default_nettype wire

// ===== tb/rsq_board.sv
// Board model: clocks, power-on reset source, pull-ups and strap resistors.
// Assumes the bench sets requests shortly after a clk_sys edge.
`timescale 1ns/1ns
`default_nettype none
module rsq_board
  import rsq_pkg::*;
(
  // Bench controls.
  input  wire logic       por_req,
  input  wire logic       ext_pull,
  input  wire rsq_strap_t strap_val,
  // Device side.
  input  wire logic       hard_oe,
  input  wire logic       soft_oe,
  input  wire logic       strap_oe,
  input  wire rsq_strap_t strap_o,
  output logic            primary_clock_in,
  output logic            bus_clock_in,
  output logic            power_on_reset_in_b,
  output logic            hard_line,
  output logic            soft_line,
  output rsq_strap_t      strap_pins
);
  initial primary_clock_in = 1'b0;
  initial bus_clock_in = 1'b0;
  always #40 primary_clock_in = ~primary_clock_in;
  always #60 bus_clock_in = ~bus_clock_in;
  assign power_on_reset_in_b = ~por_req;
  assign hard_line = ~(hard_oe | ext_pull);
  assign soft_line = ~soft_oe;
  assign strap_pins = strap_oe ? strap_o : strap_val;
endmodule : rsq_board
`default_nettype wire

// ===== tb/reset_init_sequencer_tb.sv
// Bench for the reset sequencer with the board model and checker.
// Assumes lock waits shortened to 20 and 10 cycles.
`timescale 1ns/1ns
`default_nettype none
module reset_init_sequencer_tb;
  import rsq_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst_b = 1'b0;
  logic       host_mode = 1'b1;
  logic       por_req = 1'b1;
  logic       ext_pull = 1'b0;
  rsq_strap_t strap_val = '0;
  rsq_strap_t strap_func = '0;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  rsq_strap_t exp_q[$];
  wire logic  pclk, bclk, por_b, hard_line, soft_line, hard_o, hard_oe, soft_o, soft_oe;
  wire logic  strap_oe, clocks_ready, sync_tick;
  wire rsq_strap_t strap_pins, strap_o, strap_latched;
  rsq_sequencer #(.PLL_WAIT(20), .DLL_WAIT(10)) u_rsq_sequencer (.clk_sys, .rst_b, .host_mode,
    .primary_clock_in(pclk), .bus_clock_in(bclk), .power_on_reset_in_b(por_b),
    .hard_reset_line_i(hard_line), .hard_reset_line_o(hard_o), .hard_reset_line_oe(hard_oe),
    .soft_reset_line_i(soft_line), .soft_reset_line_o(soft_o), .soft_reset_line_oe(soft_oe),
    .strap_i(strap_pins), .strap_func, .strap_o, .strap_oe, .strap_latched, .clocks_ready, .sync_tick);
  rsq_board u_rsq_board (.por_req, .ext_pull, .strap_val, .hard_oe, .soft_oe, .strap_oe, .strap_o,
    .primary_clock_in(pclk), .bus_clock_in(bclk), .power_on_reset_in_b(por_b), .hard_line,
    .soft_line, .strap_pins);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // One power-on cycle; per is the expected tick spacing in clk_sys cycles.
  task automatic run_mode(logic h, logic dv, int per);
    rsq_strap_t s;
    int n, t0, gap, pt;
    s = rsq_strap_t'(4'($urandom));
    s.input_divider_strap = dv;
    exp_q.push_back(s);
    host_mode = h;
    strap_val = s;
    strap_func = rsq_strap_t'(4'($urandom));
    por_req = 1'b1;
    repeat (40 * per) @(posedge clk_sys);
    #1 por_req = 1'b0;
    n = 0;
    pt = 0;
    t0 = cyc;
    gap = 0;
    // A tick is spent by the sequence one edge after it shows, so count it once assertion is under way.
    for (int i = 0; i < 20000 && hard_oe !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1 if (clocks_ready === 1'b1) n += pt;
      pt = int'(sync_tick);
      if (sync_tick === 1'b1) begin
        gap = cyc - t0;
        t0 = cyc;
      end
      if (i == 8) check("latched", 16'(strap_latched), 16'(exp_q.pop_front()));
      if (i == 40) check("ready", 16'(clocks_ready), 16'h1);
    end
    check("tick_gap", 16'(gap), 16'(per));
    check("hard_len", 16'(n), 16'(RST_OUT_MIN_SYNC));
    n = 0;
    while (soft_oe === 1'b1) begin
      @(posedge clk_sys);
      #1 n += int'(sync_tick);
    end
    check("soft_gap", 16'(n >= 16 && n <= 17), 16'h1);
    for (int k = 0; k < 4 * per && strap_oe !== 1'b1; k++) @(posedge clk_sys);
    #1 check("strap_oe", 16'(strap_oe), 16'h1);
    check("strap_o", 16'(strap_o), 16'(strap_func));
  endtask : run_mode
  initial begin
    void'($urandom(32'hed80));
    repeat (10) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    run_mode(1'b1, 1'b0, 8);
    run_mode(1'b1, 1'b1, 16);
    run_mode(1'b0, 1'b0, 12);
    ext_pull = 1'b1;
    repeat (10) @(posedge clk_sys iff sync_tick);
    #1 ext_pull = 1'b0;
    repeat (40) @(posedge clk_sys);
    #1 check("short_pull", 16'(hard_oe), 16'h0);
    ext_pull = 1'b1;
    repeat (40) @(posedge clk_sys iff sync_tick);
    #1 check("long_pull", 16'(hard_oe), 16'h1);
    ext_pull = 1'b0;
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    wrap_up();
  end
endmodule : reset_init_sequencer_tb
bind rsq_sequencer rsq_props #(.PLL_WAIT(PLL_WAIT)) u_rsq_props (.clk_sys, .rst_b, .power_on_reset_in_b,
  .hard_reset_line_i, .hard_reset_line_o, .hard_reset_line_oe, .soft_reset_line_o, .soft_reset_line_oe,
  .strap_oe, .strap_latched, .clocks_ready, .sync_tick);
`default_nettype wire
